/* File: ocas_top.sv */
// Ones'-complement accumulator, Q register, jump tests and shifts
`timescale 1ns/1ps
`default_nettype none
module ocas_top #(
    parameter int V_W = ocas_pkg::OCAS_V_W
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Request from the instruction sequencer
    input wire logic op_valid,
    input wire ocas_pkg::ocas_op_t op_code,
    input wire logic [35:0] op_operand,
    input wire logic [V_W-1:0] op_v,
    // Results
    output logic done,
    output logic jump_taken,
    output logic wb_valid,
    output logic [35:0] wb_data,
    output logic [71:0] acc,
    output logic [35:0] q_reg
);
    import ocas_pkg::*;

    // Ones'-complement subtract with end-around borrow; returns all ones only when a is all ones and b is zero
    function automatic logic [71:0] oc_sub(input logic [71:0] a, input logic [71:0] b);
        logic [72:0] d;
        d = {1'b0, a} - {1'b0, b};
        if (d[72]) begin
            d = d - 73'h1;
        end
        return d[71:0];
    endfunction

    function automatic logic [71:0] sext(input logic [35:0] w);
        return {{36{w[35]}}, w};
    endfunction

    logic [71:0] acc_q, acc_d;
    logic [35:0] q_q, q_d;
    logic done_q, done_d, jump_q, jump_d, wb_q, wb_d;
    logic [35:0] wbd_q, wbd_d;
    logic acc_neg_zero;
    logic [71:0] acc_eff;
    logic [71:0] diff;

    ocas_rot_if rif ();
    ocas_rotator u_rot (.rif(rif.rot));

    // All-ones accumulator reads as zero for the add and subtract
    assign acc_neg_zero = (acc_q == OCAS_ACC_ONES);
    assign acc_eff = acc_neg_zero ? 72'h0 : acc_q;
    assign diff = oc_sub(acc_eff, sext(op_operand));
    assign rif.value = (op_code == OCAS_OP_LEFT_SHIFT_Q) ? {36'h0, op_operand} : sext(op_operand);
    assign rif.count = op_v[OCAS_CNT_W-1:0];
    assign rif.sel_q = (op_code == OCAS_OP_LEFT_SHIFT_Q);

    always_comb begin
        acc_d = acc_q;
        q_d = q_q;
        done_d = op_valid;
        jump_d = 1'b0;
        wb_d = 1'b0;
        wbd_d = wbd_q;
        if (op_valid) begin
            case (op_code)
                OCAS_OP_REPLACE_ADD: begin
                    acc_d = oc_sub(acc_eff, ~sext(op_operand));
                end
                OCAS_OP_REPLACE_SUBTRACT: begin
                    acc_d = diff;
                end
                OCAS_OP_CONTROLLED_COMPLEMENT: begin
                    // Logical sum, not arithmetic: negative zero can come out
                    acc_d = {acc_q[71:36], acc_q[35:0] | op_operand};
                end
                OCAS_OP_SPLIT_POSITIVE_LOAD: begin
                    acc_d = {36'h0, op_operand};
                end
                OCAS_OP_TRANSMIT_POSITIVE: begin
                    acc_d = sext(op_operand);
                end
                OCAS_OP_EQUALITY_JUMP: begin
                    jump_d = (acc_q == sext(op_operand));
                    if (acc_neg_zero) begin
                        acc_d = 72'h0;
                    end
                end
                OCAS_OP_THRESHOLD_JUMP: begin
                    if (acc_neg_zero) begin
                        jump_d = (op_operand == 36'h0);
                        acc_d = 72'h0;
                    end else begin
                        jump_d = diff[71] && (diff != 72'h0);
                    end
                end
                OCAS_OP_ZERO_JUMP: begin
                    jump_d = (acc_q == 72'h0);
                    if (acc_neg_zero) begin
                        acc_d = 72'h0;
                    end
                end
                OCAS_OP_LEFT_SHIFT_ACCUMULATOR: begin
                    acc_d = rif.result;
                    wbd_d = rif.result[35:0];
                    // Any high v bit keeps the memory word untouched
                    wb_d = (op_v[V_W-1:OCAS_CNT_W] == '0);
                end
                OCAS_OP_LEFT_SHIFT_Q: begin
                    q_d = rif.result[35:0];
                    wbd_d = rif.result[35:0];
                    wb_d = (op_v[V_W-1:OCAS_CNT_W] == '0);
                end
                default: begin
                    done_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc_q <= OCAS_ACC_RESET;
            q_q <= OCAS_Q_RESET;
            done_q <= 1'b0;
            jump_q <= 1'b0;
            wb_q <= 1'b0;
            wbd_q <= 36'h0;
        end else begin
            acc_q <= acc_d;
            q_q <= q_d;
            done_q <= done_d;
            jump_q <= jump_d;
            wb_q <= wb_d;
            wbd_q <= wbd_d;
        end
    end

    assign done = done_q;
    assign jump_taken = jump_q;
    assign wb_valid = wb_q;
    assign wb_data = wbd_q;
    assign acc = acc_q;
    assign q_reg = q_q;

    a_arith_no_negzero: assert property (@(posedge clk_sys) disable iff (rst)
        op_valid && (op_code == OCAS_OP_REPLACE_ADD || op_code == OCAS_OP_REPLACE_SUBTRACT)
        |=> acc_q != OCAS_ACC_ONES)
        else $error("arithmetic produced negative zero");

    a_end_around_borrow: assert property (@(posedge clk_sys) disable iff (rst)
        op_valid && op_code == OCAS_OP_REPLACE_ADD && acc_q == 72'h1 && op_operand == OCAS_WORD_ONES - 36'h1
        |=> acc_q == 72'h0)
        else $error("end-around borrow wrong");

    a_split_unsigned: assert property (@(posedge clk_sys) disable iff (rst)
        op_valid && op_code == OCAS_OP_SPLIT_POSITIVE_LOAD
        |=> acc_q[71:36] == 36'h0 && acc_q[35:0] == $past(op_operand))
        else $error("split load extended operand");

    a_eq_negzero: assert property (@(posedge clk_sys) disable iff (rst)
        op_valid && op_code == OCAS_OP_EQUALITY_JUMP && acc_neg_zero && op_operand == OCAS_WORD_ONES
        |=> jump_taken && done && acc_q == 72'h0)
        else $error("equality jump on negative zero");

    a_threshold_poszero: assert property (@(posedge clk_sys) disable iff (rst)
        op_valid && op_code == OCAS_OP_THRESHOLD_JUMP && acc_neg_zero && op_operand == 36'h0
        |=> jump_taken && acc_q == 72'h0)
        else $error("threshold jump on negative zero");

    a_zero_jump_clear: assert property (@(posedge clk_sys) disable iff (rst)
        op_valid && op_code == OCAS_OP_ZERO_JUMP && acc_neg_zero
        |=> !jump_taken && acc_q == 72'h0)
        else $error("zero jump on negative zero");

    a_transmit_sext: assert property (@(posedge clk_sys) disable iff (rst)
        op_valid && op_code == OCAS_OP_TRANSMIT_POSITIVE
        |=> acc_q == {{36{$past(op_operand[35])}}, $past(op_operand)})
        else $error("transmit positive not sign extended");

    a_q_rotate: assert property (@(posedge clk_sys) disable iff (rst)
        op_valid && op_code == OCAS_OP_LEFT_SHIFT_Q && op_v[6:0] == 7'h01
        |=> q_reg == {$past(op_operand[34:0]), $past(op_operand[35])})
        else $error("q rotation wrong");

    a_wb_suppress: assert property (@(posedge clk_sys) disable iff (rst)
        op_valid && op_code == OCAS_OP_LEFT_SHIFT_ACCUMULATOR && op_v[V_W-1:OCAS_CNT_W] != '0
        |=> !wb_valid && acc_q[35:0] == wb_data)
        else $error("write-back not suppressed");

    a_complement_or_sum: assert property (@(posedge clk_sys) disable iff (rst)
        op_valid && op_code == OCAS_OP_CONTROLLED_COMPLEMENT
        |=> acc_q == {$past(acc_q[71:36]), $past(acc_q[35:0]) | $past(op_operand)})
        else $error("controlled complement is not a logical sum");

    a_negzero_as_zero: assert property (@(posedge clk_sys) disable iff (rst)
        op_valid && op_code == OCAS_OP_REPLACE_ADD && acc_neg_zero && !op_operand[35]
        |=> acc_q == {36'h0, $past(op_operand)})
        else $error("negative zero did not act as zero");

    a_threshold_negzero: assert property (@(posedge clk_sys) disable iff (rst)
        op_valid && op_code == OCAS_OP_THRESHOLD_JUMP && acc_neg_zero && op_operand == OCAS_WORD_ONES
        |=> !jump_taken && acc_q == 72'h0)
        else $error("threshold jump took v on negative zero operand");

    a_jump_clears_negzero: assert property (@(posedge clk_sys) disable iff (rst)
        op_valid && (op_code == OCAS_OP_EQUALITY_JUMP || op_code == OCAS_OP_THRESHOLD_JUMP) && acc_neg_zero
        |=> acc_q == 72'h0)
        else $error("jump test left negative zero");

    a_equality_full_width: assert property (@(posedge clk_sys) disable iff (rst)
        op_valid && op_code == OCAS_OP_EQUALITY_JUMP && !acc_neg_zero
        |=> jump_taken == ($past(acc_q) == {{36{$past(op_operand[35])}}, $past(op_operand)}))
        else $error("equality jump not over 72 bits");

    a_full_turn_rotate: assert property (@(posedge clk_sys) disable iff (rst)
        op_valid && op_code == OCAS_OP_LEFT_SHIFT_ACCUMULATOR && op_v[6:0] == 7'h48
        |=> acc_q == {{36{$past(op_operand[35])}}, $past(op_operand)})
        else $error("full accumulator turn changed the value");

    a_q_wb_suppress: assert property (@(posedge clk_sys) disable iff (rst)
        op_valid && op_code == OCAS_OP_LEFT_SHIFT_Q && op_v[V_W-1:OCAS_CNT_W] != '0
        |=> !wb_valid)
        else $error("q write-back not suppressed");

    // Every accepted op answers one cycle later, and only then
    a_done_follows_op: assert property (@(posedge clk_sys) disable iff (rst)
        1'b1 |=> done == $past(op_valid))
        else $error("done pulse out of step with requests");
endmodule // ocas_top
`default_nettype wire

/* File: ocas_pkg.sv */
// Shared constants and types for the ones'-complement accumulator and shifter
package ocas_pkg;
    localparam int OCAS_WORD_W = 36;
    localparam int OCAS_ACC_W = 72;
    localparam int OCAS_V_W = 15;
    localparam int OCAS_CNT_W = 7;
    localparam logic [6:0] OCAS_ACC_MOD = 7'h48;
    localparam logic [6:0] OCAS_Q_MOD = 7'h24;
    localparam logic [71:0] OCAS_ACC_RESET = 72'h0;
    localparam logic [35:0] OCAS_Q_RESET = 36'h0;
    localparam logic [71:0] OCAS_ACC_ONES = {72{1'b1}};
    localparam logic [35:0] OCAS_WORD_ONES = {36{1'b1}};

    typedef enum logic [3:0] {
        OCAS_OP_REPLACE_ADD,
        OCAS_OP_REPLACE_SUBTRACT,
        OCAS_OP_CONTROLLED_COMPLEMENT,
        OCAS_OP_SPLIT_POSITIVE_LOAD,
        OCAS_OP_TRANSMIT_POSITIVE,
        OCAS_OP_EQUALITY_JUMP,
        OCAS_OP_THRESHOLD_JUMP,
        OCAS_OP_ZERO_JUMP,
        OCAS_OP_LEFT_SHIFT_ACCUMULATOR,
        OCAS_OP_LEFT_SHIFT_Q
    } ocas_op_t;
endpackage

/* File: ocas_rot_if.sv */
// Carrier between the top and the end-around rotator
`timescale 1ns/1ps
`default_nettype none
interface ocas_rot_if;
    logic [71:0] value;
    logic [6:0] count;
    logic sel_q;
    logic [71:0] result;
    modport ctrl (output value, output count, output sel_q, input result);
    modport rot (input value, input count, input sel_q, output result);
endinterface
`default_nettype wire

/* File: ocas_rotator.sv */
// Left end-around rotator, 72-bit accumulator or 36-bit Q modulus
`timescale 1ns/1ps
`default_nettype none
module ocas_rotator (
    ocas_rot_if.rot rif
);
    import ocas_pkg::*;

    logic [6:0] k;
    logic [143:0] wide;
    logic [71:0] dbl;

    always_comb begin
        dbl = 72'h0;
        if (rif.sel_q) begin
            k = rif.count % OCAS_Q_MOD;
            dbl = {rif.value[35:0], rif.value[35:0]};
            wide = {72'h0, dbl} << k;
            rif.result = {36'h0, wide[71:36]};
        end else begin
            k = rif.count % OCAS_ACC_MOD;
            wide = {rif.value, rif.value} << k;
            rif.result = wide[143:72];
        end
    end
endmodule // ocas_rotator
`default_nettype wire

/* File: ocas_tb.sv */
// Self-checking testbench for the ones'-complement accumulator and shifter
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("BAD %0t mismatch got %h exp %h", $time, a, e); end end
module tb;
    import ocas_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic op_valid = 1'b0;
    ocas_op_t op_code = OCAS_OP_REPLACE_ADD;
    logic [35:0] op_operand = 36'h0;
    logic [14:0] op_v = 15'h0;
    logic done, jump_taken, wb_valid;
    logic [35:0] wb_data, q_reg;
    logic [71:0] acc;
    int n_errors = 0;
    int total_checks = 0;
    localparam logic [35:0] ONES = 36'hFFFFFFFFF;

    always #12.5 clk_sys = ~clk_sys;

    ocas_top u_ocas_top (.clk_sys(clk_sys), .rst(rst), .op_valid(op_valid), .op_code(op_code),
        .op_operand(op_operand), .op_v(op_v), .done(done), .jump_taken(jump_taken),
        .wb_valid(wb_valid), .wb_data(wb_data), .acc(acc), .q_reg(q_reg));

    function automatic logic [71:0] rl72(input logic [71:0] a, input int k);
        return (k % 72 == 0) ? a : (a << (k % 72)) | (a >> (72 - k % 72));
    endfunction
    function automatic logic [35:0] rl36(input logic [35:0] a, input int k);
        return (k % 36 == 0) ? a : (a << (k % 36)) | (a >> (36 - k % 36));
    endfunction

    // One operation; outputs are sampled in the cycle done stands
    task automatic op(input ocas_op_t c, input logic [35:0] u, input logic [14:0] v);
        @(posedge clk_sys);
        op_valid <= 1'b1;
        op_code <= c;
        op_operand <= u;
        op_v <= v;
        @(posedge clk_sys);
        op_valid <= 1'b0;
        #1;
        `CHK(done, 1'b1)
    endtask

    // Logical sum builds negative zero, which arithmetic cannot
    task automatic make_negzero();
        op(OCAS_OP_TRANSMIT_POSITIVE, 36'h800000000, 15'h0);
        op(OCAS_OP_CONTROLLED_COMPLEMENT, 36'h7FFFFFFFF, 15'h0);
        `CHK(acc, OCAS_ACC_ONES)
    endtask

    task automatic t_arith();
        op(OCAS_OP_TRANSMIT_POSITIVE, 36'h0, 15'h0);
        op(OCAS_OP_REPLACE_ADD, 36'hFFFFFFFFE, 15'h0);
        `CHK(acc, {ONES, 36'hFFFFFFFFE})
        op(OCAS_OP_REPLACE_ADD, 36'h1, 15'h0);
        `CHK(acc, 72'h0)
        op(OCAS_OP_REPLACE_SUBTRACT, ONES, 15'h0);
        `CHK(acc, 72'h0)
        op(OCAS_OP_REPLACE_ADD, 36'h5, 15'h0);
        op(OCAS_OP_REPLACE_ADD, 36'hFFFFFFFFC, 15'h0);
        `CHK(acc, 72'h2)
        op(OCAS_OP_REPLACE_SUBTRACT, 36'h1, 15'h0);
        `CHK(acc, 72'h1)
        op(OCAS_OP_REPLACE_ADD, 36'hFFFFFFFFE, 15'h0);
        `CHK(acc, 72'h0)
        $display("test arith done");
    endtask

    task automatic t_negzero();
        op(OCAS_OP_SPLIT_POSITIVE_LOAD, ONES, 15'h0);
        `CHK(acc, {36'h0, ONES})
        make_negzero();
        op(OCAS_OP_REPLACE_ADD, 36'h5, 15'h0);
        `CHK(acc, 72'h5)
        make_negzero();
        op(OCAS_OP_EQUALITY_JUMP, ONES, 15'h0);
        `CHK(jump_taken, 1'b1)
        `CHK(acc, 72'h0)
        make_negzero();
        op(OCAS_OP_THRESHOLD_JUMP, ONES, 15'h0);
        `CHK(jump_taken, 1'b0)
        `CHK(acc, 72'h0)
        make_negzero();
        op(OCAS_OP_EQUALITY_JUMP, 36'h0, 15'h0);
        `CHK(jump_taken, 1'b0)
        make_negzero();
        op(OCAS_OP_THRESHOLD_JUMP, 36'h0, 15'h0);
        `CHK(jump_taken, 1'b1)
        `CHK(acc, 72'h0)
        make_negzero();
        op(OCAS_OP_ZERO_JUMP, 36'h0, 15'h0);
        `CHK(jump_taken, 1'b0)
        `CHK(acc, 72'h0)
        op(OCAS_OP_ZERO_JUMP, 36'h0, 15'h0);
        `CHK(jump_taken, 1'b1)
        $display("test negative zero done");
    endtask

    task automatic t_ext();
        op(OCAS_OP_SPLIT_POSITIVE_LOAD, 36'h800000000, 15'h0);
        op(OCAS_OP_EQUALITY_JUMP, 36'h800000000, 15'h0);
        `CHK(jump_taken, 1'b0)
        op(OCAS_OP_TRANSMIT_POSITIVE, 36'h800000000, 15'h0);
        `CHK(acc, {ONES, 36'h800000000})
        op(OCAS_OP_EQUALITY_JUMP, 36'h800000000, 15'h0);
        `CHK(jump_taken, 1'b1)
        op(OCAS_OP_TRANSMIT_POSITIVE, 36'h3, 15'h0);
        op(OCAS_OP_THRESHOLD_JUMP, 36'h5, 15'h0);
        `CHK(jump_taken, 1'b1)
        op(OCAS_OP_THRESHOLD_JUMP, 36'h3, 15'h0);
        `CHK(jump_taken, 1'b0)
        $display("test extension done");
    endtask

    task automatic t_shift();
        logic [71:0] a;
        logic [71:0] r;
        int ks[3];
        a = {ONES, 36'h800000001};
        ks = '{5, 67, 72};
        foreach (ks[i]) begin
            r = rl72(a, ks[i]);
            op(OCAS_OP_LEFT_SHIFT_ACCUMULATOR, 36'h800000001, 15'(ks[i]));
            `CHK(acc, r)
            `CHK(wb_valid, 1'b1)
            `CHK(wb_data, r[35:0])
        end
        r = rl72(a, 5);
        op(OCAS_OP_LEFT_SHIFT_ACCUMULATOR, 36'h800000001, 15'h0085);
        `CHK(wb_valid, 1'b0)
        `CHK(acc, r)
        `CHK(wb_data, r[35:0])
        op(OCAS_OP_LEFT_SHIFT_Q, 36'h800000001, 15'h0003);
        `CHK(q_reg, rl36(36'h800000001, 3))
        `CHK(wb_valid, 1'b1)
        op(OCAS_OP_LEFT_SHIFT_Q, 36'h800000001, 15'h4024);
        `CHK(q_reg, 36'h800000001)
        `CHK(wb_valid, 1'b0)
        $display("test shift done");
    endtask

    // Reset in mid-run must drop every register, then ops resume
    task automatic t_reset();
        op(OCAS_OP_LEFT_SHIFT_Q, 36'h800000001, 15'h0001);
        `CHK(q_reg, rl36(36'h800000001, 1))
        `CHK(wb_data, rl36(36'h800000001, 1))
        @(posedge clk_sys);
        rst <= 1'b1;
        @(posedge clk_sys);
        #1;
        `CHK(acc, OCAS_ACC_RESET)
        `CHK(q_reg, OCAS_Q_RESET)
        `CHK(wb_data, 36'h0)
        `CHK(done, 1'b0)
        `CHK(wb_valid, 1'b0)
        `CHK(jump_taken, 1'b0)
        @(posedge clk_sys);
        rst <= 1'b0;
        op(OCAS_OP_LEFT_SHIFT_Q, 36'h800000001, 15'h0001);
        `CHK(q_reg, rl36(36'h800000001, 1))
        `CHK(wb_valid, 1'b1)
        $display("test reset done");
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog against a hung run
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_errors++;
        $display("BAD %0t run did not finish", $time);
        summarize();
    end

    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        t_arith();
        t_negzero();
        t_ext();
        t_shift();
        t_reset();
        summarize();
    end
endmodule // tb
`default_nettype wire
